/* prebyte_decoder_pkg.sv */
// Shared encodings for the prefix-aware instruction fetch and decoder.
// Assumes byte-wide program memory and a 16-bit program counter.
package prebyte_decoder_pkg;

  // Prefix byte codes
  localparam logic [7:0] PFX_Y_INDEX = 8'h90;
  localparam logic [7:0] PFX_INDIRECT = 8'h92;
  localparam logic [7:0] PFX_Y_INDIRECT = 8'h91;

  // Opcodes with a fixed meaning outside the row layout
  localparam logic [7:0] OPC_REL_CALL = 8'hAD;
  localparam logic [7:0] OPC_MUL = 8'h42;

  // Program counter after reset
  localparam logic [15:0] RESET_PC = 16'h0000;
  // Page of short pointers and short indirect addresses
  localparam logic [7:0] PTR_PAGE = 8'h00;

  // Size of the instruction set
  localparam int INSTR_COUNT = 63;

  typedef enum logic [1:0] {
    PF_NONE, PF_Y, PF_IND, PF_YIND
  } prefix_e;

  typedef enum logic [3:0] {
    AM_INH, AM_IMM, AM_DIR, AM_EXT, AM_IX, AM_IX8, AM_IX16,
    AM_REL, AM_BIT, AM_BITREL
  } amode_e;

  // Operations, ordered by group; I_RSV marks an undefined opcode
  typedef enum logic [5:0] {
    I_LD, I_CLR, I_PUSH, I_POP, I_RSP, I_INC, I_DEC,
    I_CP, I_TNZ, I_BCP, I_AND, I_OR, I_XOR, I_CPL, I_NEG,
    I_BSET, I_BRES, I_BTJT, I_BTJF,
    I_ADC, I_ADD, I_SUB, I_SBC, I_MUL,
    I_SLL, I_SRL, I_SRA, I_RLC, I_RRC, I_SWAP,
    I_JP, I_CALL, I_RELCALL, I_NOP, I_RET, I_RELJUMP,
    I_TRAP, I_WFI, I_HALT, I_IRET,
    I_SIM, I_RIM, I_SCF, I_RCF, I_RSV
  } op_e;

  function automatic prefix_e prefixOf(input logic [7:0] b);
    case (b)
      PFX_Y_INDEX: prefixOf = PF_Y;
      PFX_INDIRECT: prefixOf = PF_IND;
      PFX_Y_INDIRECT: prefixOf = PF_YIND;
      default: prefixOf = PF_NONE;
    endcase
  endfunction : prefixOf

endpackage : prebyte_decoder_pkg

/* opcode_classifier.sv */
// Combinational opcode classifier: operation, mode, byte count, legality.
// Assumes the caller supplies the pending prefix, or none.
`timescale 1ns/1ps
module opcode_classifier (
  // Byte under decode and pending prefix
  input wire logic [7:0] opcode,
  input wire prebyte_decoder_pkg::prefix_e prefix,
  // Decode result
  output prebyte_decoder_pkg::op_e op,
  output prebyte_decoder_pkg::amode_e mode,
  output logic [1:0] extraBytes,
  output logic longPtr,
  output logic useY,
  output logic indirect,
  output logic legal
);
  import prebyte_decoder_pkg::*;

  logic [3:0] row;
  logic [3:0] col;
  logic aluRow;
  logic xCol;
  logic idxMode;
  logic yOk;
  logic indOk;
  logic yIndOk;
  logic prefixOk;

  function automatic op_e aluOp(input logic [3:0] c);
    case (c)
      4'h0: aluOp = I_SUB;
      4'h1, 4'h3: aluOp = I_CP;
      4'h2: aluOp = I_SBC;
      4'h4: aluOp = I_AND;
      4'h5: aluOp = I_BCP;
      4'h8: aluOp = I_XOR;
      4'h9: aluOp = I_ADC;
      4'hA: aluOp = I_OR;
      4'hB: aluOp = I_ADD;
      4'hC: aluOp = I_JP;
      4'hD: aluOp = I_CALL;
      default: aluOp = I_LD;
    endcase
  endfunction : aluOp

  function automatic op_e rmwOp(input logic [7:0] opc);
    case (opc[3:0])
      4'h0: rmwOp = I_NEG;
      4'h2: rmwOp = (opc == OPC_MUL) ? I_MUL : I_RSV;
      4'h3: rmwOp = I_CPL;
      4'h4: rmwOp = I_SRL;
      4'h6: rmwOp = I_RRC;
      4'h7: rmwOp = I_SRA;
      4'h8: rmwOp = I_SLL;
      4'h9: rmwOp = I_RLC;
      4'hA: rmwOp = I_DEC;
      4'hC: rmwOp = I_INC;
      4'hD: rmwOp = I_TNZ;
      4'hE: rmwOp = I_SWAP;
      4'hF: rmwOp = I_CLR;
      default: rmwOp = I_RSV;
    endcase
  endfunction : rmwOp

  function automatic op_e miscOp(input logic [4:0] k);
    case (k)
      5'h00: miscOp = I_IRET;
      5'h01: miscOp = I_RET;
      5'h03: miscOp = I_TRAP;
      5'h04: miscOp = I_POP;
      5'h08: miscOp = I_PUSH;
      5'h0E: miscOp = I_HALT;
      5'h0F: miscOp = I_WFI;
      5'h14: miscOp = I_RSP;
      5'h17: miscOp = I_LD;
      5'h18: miscOp = I_RCF;
      5'h19: miscOp = I_SCF;
      5'h1A: miscOp = I_RIM;
      5'h1B: miscOp = I_SIM;
      5'h1D: miscOp = I_NOP;
      default: miscOp = I_RSV;
    endcase
  endfunction : miscOp

  assign row = opcode[7:4];
  assign col = opcode[3:0];

  always_comb begin
    case (row)
      4'h0: op = col[0] ? I_BTJF : I_BTJT;
      4'h1: op = col[0] ? I_BRES : I_BSET;
      4'h2: op = I_RELJUMP;
      4'h3, 4'h4, 4'h5, 4'h6, 4'h7: op = rmwOp(opcode);
      4'h8, 4'h9: op = miscOp({row[0], col});
      4'hA: begin
        case (col)
          4'h7, 4'hC, 4'hF: op = I_RSV;
          4'hD: op = I_RELCALL;
          default: op = aluOp(col);
        endcase
      end
      default: op = aluOp(col);
    endcase
  end

  always_comb begin
    case (row)
      4'h0: mode = AM_BITREL;
      4'h1: mode = AM_BIT;
      4'h2: mode = AM_REL;
      4'h3, 4'hB: mode = AM_DIR;
      4'h6, 4'hE: mode = AM_IX8;
      4'h7, 4'hF: mode = AM_IX;
      4'hA: mode = (opcode == OPC_REL_CALL) ? AM_REL : AM_IMM;
      4'hC: mode = AM_EXT;
      4'hD: mode = AM_IX16;
      default: mode = AM_INH;
    endcase
  end

  assign useY = (prefix == PF_Y) || (prefix == PF_YIND);
  assign indirect = (prefix == PF_IND) || (prefix == PF_YIND);

  always_comb begin
    case (mode)
      AM_EXT, AM_IX16: extraBytes = indirect ? 2'h1 : 2'h2;
      AM_BITREL: extraBytes = 2'h2;
      AM_INH, AM_IX: extraBytes = 2'h0;
      default: extraBytes = 2'h1;
    endcase
  end

  assign longPtr = indirect && ((mode == AM_EXT) || (mode == AM_IX16));

  assign aluRow = row >= 4'hA;
  assign xCol = (col == 4'h3) || (col == 4'hE) || (col == 4'hF);
  assign idxMode = (mode == AM_IX) || (mode == AM_IX8) || (mode == AM_IX16);
  assign yOk = idxMode || (row == 4'h5) || (op == I_MUL) ||
               (aluRow && xCol && (mode != AM_REL));
  assign indOk = (mode == AM_DIR) || (mode == AM_EXT) ||
                 (mode == AM_BIT) || (mode == AM_BITREL) ||
                 (mode == AM_REL) || (mode == AM_IX8) ||
                 (mode == AM_IX16);
  assign yIndOk = (mode == AM_IX8) || (mode == AM_IX16);

  always_comb begin
    case (prefix)
      PF_Y: prefixOk = yOk;
      PF_IND: prefixOk = indOk;
      PF_YIND: prefixOk = yIndOk;
      default: prefixOk = 1'b1;
    endcase
  end

  assign legal = (op != I_RSV) && prefixOk;

endmodule : opcode_classifier

/* prebyte_relative_decoder.sv */
// Instruction fetch and decode with prefix bytes and relative targets.
// Assumes a byte-wide program memory on mclk acking at most one read per cycle
// while memReq is high, and a datapath taking instructions by valid/ready.
`timescale 1ns/1ps
module prebyte_relative_decoder (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Program memory read port
  output logic memReq,
  output logic [15:0] memAddr,
  input wire logic [7:0] memRdata,
  input wire logic memAck,
  // Decoded instruction to the datapath
  output logic instValid,
  input wire logic instReady,
  output prebyte_decoder_pkg::op_e instOp,
  output prebyte_decoder_pkg::amode_e instMode,
  output logic [3:0] instSel,
  output logic instUseY,
  output logic instIndirect,
  output logic [15:0] instOperand,
  output logic [15:0] instRelTarget,
  output logic [15:0] instNextPc,
  output logic [2:0] instLength,
  output logic rsvdSeen,
  // Program counter redirect from the datapath
  input wire logic pcLoad,
  input wire logic [15:0] pcLoadValue
);
  import prebyte_decoder_pkg::*;

  typedef enum logic [2:0] {
    S_START, S_FIRST, S_OPCODE, S_OPER, S_PTR, S_LATCH, S_ISSUE
  } state_e;

  state_e state;
  state_e next_state;

  // Fetch position and captured bytes
  logic [15:0] pc;
  prefix_e prefix;
  logic [7:0] opcode;
  logic [7:0] op1;
  logic [7:0] op2;
  logic byteIdx;
  logic ptrIdx;
  logic [15:0] ptr;
  logic [2:0] len;

  // Decode held for the current instruction
  op_e decOp;
  amode_e decMode;
  logic [1:0] decExtra;
  logic decLong;
  logic decUseY;
  logic decInd;

  // Classifier view of the incoming byte
  op_e clsOp;
  amode_e clsMode;
  logic [1:0] clsExtra;
  logic clsLong;
  logic clsUseY;
  logic clsInd;
  logic clsLegal;
  prefix_e clsPrefix;
  prefix_e firstPrefix;

  // Handshake and sequencing terms
  logic byteTaken;
  logic inFetch;
  logic takePrefix;
  logic takeRsvd;
  logic takeOpcode;
  logic takeOper;
  logic takePtr;
  logic fetchByte;
  logic lastOper;
  logic operEnd;
  logic ptrDone;
  logic ptrEnd;
  logic accept;
  logic stopFetch;
  logic [15:0] pcPlus1;
  logic [15:0] addrStep;
  logic [15:0] redirectPc;
  logic [7:0] ptrBase;
  logic [7:0] relOffset;
  logic [15:0] relTarget;
  logic [15:0] operandVal;

  // The byte in flight is decoded before it is stored
  opcode_classifier u_classifier (
    .opcode(memRdata),
    .prefix(clsPrefix),
    .op(clsOp),
    .mode(clsMode),
    .extraBytes(clsExtra),
    .longPtr(clsLong),
    .useY(clsUseY),
    .indirect(clsInd),
    .legal(clsLegal)
  );

  assign byteTaken = memReq && memAck;
  assign inFetch = (state == S_FIRST) || (state == S_OPCODE);
  assign firstPrefix = prefixOf(memRdata);
  // prefix reaches only the next byte
  assign clsPrefix = (state == S_OPCODE) ? prefix : PF_NONE;

  assign takePrefix = byteTaken && (state == S_FIRST) &&
                      (firstPrefix != PF_NONE);
  assign takeRsvd = byteTaken && inFetch && !takePrefix && !clsLegal;
  assign takeOpcode = byteTaken && inFetch && !takePrefix && clsLegal;
  assign takeOper = byteTaken && (state == S_OPER);
  assign takePtr = byteTaken && (state == S_PTR);
  assign fetchByte = takePrefix || takeRsvd || takeOpcode || takeOper;
  assign accept = (state == S_ISSUE) && instReady;

  assign lastOper = ({1'b0, byteIdx} + 2'h1) == decExtra;
  assign operEnd = takeOper && lastOper;
  assign ptrDone = !decLong || ptrIdx;
  assign ptrEnd = takePtr && ptrDone;
  assign stopFetch = (takeOpcode && (clsExtra == 2'h0)) ||
                     (operEnd && !decInd) || ptrEnd;

  assign pcPlus1 = pc + 16'h0001;
  assign addrStep = memAddr + 16'h0001;
  assign redirectPc = pcLoad ? pcLoadValue : pc;
  // pointer address is the first operand byte
  assign ptrBase = (byteIdx == 1'b0) ? memRdata : op1;

  assign relOffset = (decMode == AM_BITREL) ? op2 :
                     (decInd ? ptr[7:0] : op1);
  // signed offset added to the program counter
  assign relTarget = pc + {{8{relOffset[7]}}, relOffset};
  assign operandVal = decInd ? ptr :
                      ((decExtra == 2'h2) && (decMode != AM_BITREL)) ?
                      {op1, op2} : {PTR_PAGE, op1};

  always_comb begin
    next_state = state;
    case (state)
      S_START: next_state = S_FIRST;
      S_FIRST, S_OPCODE: begin
        if (takePrefix) begin
          next_state = S_OPCODE;
        end else if (takeRsvd) begin
          next_state = S_FIRST;
        end else if (takeOpcode) begin
          next_state = (clsExtra == 2'h0) ? S_LATCH : S_OPER;
        end
      end
      S_OPER: begin
        if (operEnd) begin
          next_state = decInd ? S_PTR : S_LATCH;
        end
      end
      S_PTR: begin
        if (ptrEnd) begin
          next_state = S_LATCH;
        end
      end
      S_LATCH: next_state = S_ISSUE;
      S_ISSUE: begin
        if (instReady) begin
          next_state = S_FIRST;
        end
      end
      default: next_state = S_START;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= S_START;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pc <= RESET_PC;
    end else if (accept) begin
      pc <= redirectPc;
    end else if (fetchByte) begin
      pc <= pcPlus1;
    end
  end

  // Memory request stays up across back-to-back reads
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      memReq <= 1'b0;
    end else if ((state == S_START) || accept) begin
      memReq <= 1'b1;
    end else if (stopFetch) begin
      memReq <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      memAddr <= RESET_PC;
    end else if (state == S_START) begin
      memAddr <= pc;
    end else if (accept) begin
      memAddr <= redirectPc;
    end else if (operEnd && decInd) begin
      memAddr <= {PTR_PAGE, ptrBase};
    end else if (takePtr) begin
      memAddr <= addrStep;
    end else if (fetchByte) begin
      memAddr <= pcPlus1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prefix <= PF_NONE;
    end else if (takePrefix) begin
      prefix <= firstPrefix;
    end else if (takeRsvd || accept) begin
      prefix <= PF_NONE;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      opcode <= 8'h00;
      decOp <= I_NOP;
      decMode <= AM_INH;
      decExtra <= 2'h0;
      decLong <= 1'b0;
      decUseY <= 1'b0;
      decInd <= 1'b0;
    end else if (takeOpcode) begin
      opcode <= memRdata;
      decOp <= clsOp;
      decMode <= clsMode;
      decExtra <= clsExtra;
      decLong <= clsLong;
      decUseY <= clsUseY;
      decInd <= clsInd;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      len <= 3'h0;
    end else if (takePrefix) begin
      len <= 3'h1;
    end else if (takeOpcode) begin
      len <= (state == S_OPCODE) ? 3'h2 : 3'h1;
    end else if (takeOper) begin
      len <= len + 3'h1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      op1 <= 8'h00;
      op2 <= 8'h00;
      byteIdx <= 1'b0;
    end else if (takeOpcode) begin
      byteIdx <= 1'b0;
    end else if (takeOper) begin
      byteIdx <= 1'b1;
      if (byteIdx == 1'b0) begin
        op1 <= memRdata;
      end else begin
        op2 <= memRdata;
      end
    end
  end

  // pointer or offset read from memory
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ptr <= 16'h0000;
      ptrIdx <= 1'b0;
    end else if (operEnd) begin
      ptrIdx <= 1'b0;
    end else if (takePtr) begin
      ptrIdx <= 1'b1;
      if (decLong && !ptrIdx) begin
        ptr[15:8] <= memRdata;
      end else if (decLong) begin
        ptr[7:0] <= memRdata;
      end else begin
        ptr <= {PTR_PAGE, memRdata};
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      instValid <= 1'b0;
    end else if (state == S_LATCH) begin
      instValid <= 1'b1;
    end else if (accept) begin
      instValid <= 1'b0;
    end
  end

  // Results frozen while the instruction is offered
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      instOp <= I_NOP;
      instMode <= AM_INH;
      instSel <= 4'h0;
      instUseY <= 1'b0;
      instIndirect <= 1'b0;
      instOperand <= 16'h0000;
      instRelTarget <= RESET_PC;
      instNextPc <= RESET_PC;
      instLength <= 3'h0;
    end else if (state == S_LATCH) begin
      instOp <= decOp;
      instMode <= decMode;
      instSel <= opcode[3:0];
      instUseY <= decUseY;
      instIndirect <= decInd;
      instOperand <= operandVal;
      // target for jumps and relative call
      instRelTarget <= relTarget;
      instNextPc <= pc;
      instLength <= len;
    end
  end

  // one-cycle notice of a dropped opcode, alone or with its prefix
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rsvdSeen <= 1'b0;
    end else begin
      rsvdSeen <= takeRsvd;
    end
  end

endmodule : prebyte_relative_decoder

/* prebyte_relative_decoder_sva.sv */
// Checker for the prefix-aware decoder, seeing only its top ports.
// Assumes the decoder package is compiled first.
`timescale 1ns/1ps
module prebyte_relative_decoder_chk
  import prebyte_decoder_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Memory port
  input wire logic memReq,
  input wire logic [15:0] memAddr,
  input wire logic memAck,
  // Datapath port
  input wire logic instValid,
  input wire logic instReady,
  input wire prebyte_decoder_pkg::op_e instOp,
  input wire prebyte_decoder_pkg::amode_e instMode,
  input wire logic instUseY,
  input wire logic instIndirect,
  input wire logic [15:0] instOperand,
  input wire logic [15:0] instRelTarget,
  input wire logic [15:0] instNextPc,
  input wire logic [2:0] instLength,
  input wire logic rsvdSeen,
  input wire logic pcLoad,
  input wire logic [15:0] pcLoadValue
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_rel_target;
    instValid && instMode == AM_REL |-> instRelTarget ==
      instNextPc + {{8{instOperand[7]}}, instOperand[7:0]};
  endproperty
  a_rel_target: assert property (p_rel_target)
    else $error("relative target is not next pc plus signed offset");

  property p_direct_rel;
    instValid && instMode == AM_REL && !instIndirect |->
      instOperand[15:8] == 8'h00 && instLength == 3'h2;
  endproperty
  a_direct_rel: assert property (p_direct_rel)
    else $error("direct relative form has wrong operand or length");

  property p_ind_rel;
    instValid && instMode == AM_REL && instIndirect |->
      instOperand[15:8] == 8'h00 && instLength == 3'h3;
  endproperty
  a_ind_rel: assert property (p_ind_rel)
    else $error("indirect relative form has wrong pointer or length");

  property p_hold_valid;
    instValid && !instReady |=> instValid && $stable(instOp) &&
      $stable(instOperand) && $stable(instRelTarget);
  endproperty
  a_hold_valid: assert property (p_hold_valid)
    else $error("offered instruction changed before accept");

  property p_len;
    instValid |-> instLength inside {[3'h1:3'h4]};
  endproperty
  a_len: assert property (p_len)
    else $error("instruction length outside one to four");

  property p_fetch_after_accept;
    instValid && instReady |=> memReq && memAddr == ($past(pcLoad) ?
      $past(pcLoadValue) : $past(instNextPc));
  endproperty
  a_fetch_after_accept: assert property (p_fetch_after_accept)
    else $error("fetch does not resume at the right address");

  property p_addr_hold;
    memReq && !memAck |=> memReq && $stable(memAddr);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("read request dropped or moved before ack");

  property p_issue_gap;
    instValid && instReady |=> !instValid [*2];
  endproperty
  a_issue_gap: assert property (p_issue_gap)
    else $error("next instruction offered too soon after accept");

  property p_y_prefix;
    instValid && instUseY |-> instLength >= 3'h2;
  endproperty
  a_y_prefix: assert property (p_y_prefix)
    else $error("Y form without room for a prefix byte");

  property p_ind_modes;
    instValid && instIndirect |-> instMode inside
      {AM_DIR, AM_EXT, AM_BIT, AM_BITREL, AM_REL, AM_IX8, AM_IX16};
  endproperty
  a_ind_modes: assert property (p_ind_modes)
    else $error("indirect form on a mode without one");

  property p_yind;
    instValid && instUseY && instIndirect |-> instMode inside
      {AM_IX8, AM_IX16};
  endproperty
  a_yind: assert property (p_yind)
    else $error("Y indirect form outside indexed modes");

  property p_no_rsvd;
    instValid |-> instOp != I_RSV && !rsvdSeen;
  endproperty
  a_no_rsvd: assert property (p_no_rsvd)
    else $error("reserved combination issued to datapath");

  property p_rsvd_pulse;
    rsvdSeen |=> !rsvdSeen;
  endproperty
  a_rsvd_pulse: assert property (p_rsvd_pulse)
    else $error("reserved flag longer than one cycle");

  c_rel_ind: cover property (instValid && instIndirect && instMode == AM_REL);
  c_rsvd: cover property (rsvdSeen);
  c_stall: cover property (memReq && !memAck);
  c_yind: cover property (instValid && instUseY && instIndirect);
endmodule : prebyte_relative_decoder_chk

bind prebyte_relative_decoder prebyte_relative_decoder_chk chkU (
  .mclk(mclk), .rstn(rstn), .memReq(memReq), .memAddr(memAddr),
  .memAck(memAck), .instValid(instValid), .instReady(instReady),
  .instOp(instOp), .instMode(instMode), .instUseY(instUseY),
  .instIndirect(instIndirect), .instOperand(instOperand),
  .instRelTarget(instRelTarget), .instNextPc(instNextPc),
  .instLength(instLength), .rsvdSeen(rsvdSeen), .pcLoad(pcLoad),
  .pcLoadValue(pcLoadValue)
);

/* prog_mem_model.sv */
// Program memory model: 256 bytes, same-cycle or every-other-cycle ack.
// Assumes the bench fills mem before reset is released.
`timescale 1ns/1ps
module prog_mem_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Read port
  input wire logic memReq,
  input wire logic [15:0] memAddr,
  output logic [7:0] memRdata,
  output logic memAck,
  // Slow mode
  input wire logic slow
);
  logic [7:0] mem [0:255];
  logic phase;
  logic [7:0] lastData;

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'h9D;
  end

  // Data line shows junk when not acking
  assign memAck = memReq & (~slow | phase);
  assign memRdata = memAck ? mem[memAddr[7:0]] : ~lastData;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      phase <= 1'b0;
      lastData <= 8'h00;
    end else begin
      phase <= memReq & ~phase;
      if (memAck) lastData <= memRdata;
    end
  end
endmodule : prog_mem_model

/* prebyte_relative_decoder_tb_top.sv */
// Self-checking bench: runs a fixed program through the decoder.
// Assumes the memory model and the bound checker are compiled first.
`timescale 1ns/1ps
module prebyte_relative_decoder_tb_top;
  import prebyte_decoder_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic memReq, memAck, slow = 1'b0;
  logic [15:0] memAddr;
  logic [7:0] memRdata;
  logic instValid, instReady = 1'b0, pcLoad = 1'b0;
  op_e instOp;
  amode_e instMode;
  logic [3:0] instSel;
  logic instUseY, instIndirect, rsvdSeen;
  logic [15:0] instOperand, instRelTarget, instNextPc;
  logic [15:0] pcLoadValue = 16'h0000;
  logic [2:0] instLength;
  int err_count = 0, compares = 0, cyc = 0, rsvdCnt = 0, n0;
  logic [7:0] prog [0:42] = '{8'h20, 8'h05, 8'h2F, 8'hF0, 8'h9D, 8'h9D,
    8'h9D, 8'h9D, 8'h9D, 8'h9D, 8'h9D, 8'h9D, 8'h9D, 8'h9D, 8'h9D, 8'h9D,
    8'h92, 8'h22, 8'h40, 8'hAD, 8'h7F, 8'h90, 8'h5C, 8'h90, 8'h20, 8'h9D,
    8'h91, 8'hE6, 8'h30, 8'h92, 8'hE6, 8'h30, 8'h92, 8'hC6, 8'h40, 8'h90,
    8'hD6, 8'h12, 8'h34, 8'h92, 8'h01, 8'h30, 8'h03};

  always #5 mclk = ~mclk;

  prebyte_relative_decoder dut_u (.mclk(mclk), .rstn(rstn),
    .memReq(memReq), .memAddr(memAddr), .memRdata(memRdata),
    .memAck(memAck), .instValid(instValid), .instReady(instReady),
    .instOp(instOp), .instMode(instMode), .instSel(instSel),
    .instUseY(instUseY), .instIndirect(instIndirect),
    .instOperand(instOperand), .instRelTarget(instRelTarget),
    .instNextPc(instNextPc), .instLength(instLength),
    .rsvdSeen(rsvdSeen), .pcLoad(pcLoad), .pcLoadValue(pcLoadValue));

  prog_mem_model memU (.mclk(mclk), .rstn(rstn), .memReq(memReq),
    .memAddr(memAddr), .memRdata(memRdata), .memAck(memAck), .slow(slow));

  always @(posedge mclk) begin
    cyc++;
    if (rsvdSeen === 1'b1) rsvdCnt++;
    if (cyc == 3000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    if (err_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // Wait for an offer, check it, stall, then accept
  task automatic take(input op_e op, input logic [2:0] len,
    input logic [15:0] nxt, input logic [15:0] tgt,
    input logic [15:0] opnd, input logic y, input logic ind,
    input logic [1:0] m, input logic ld, input logic [15:0] ldv);
    int n;
    n = 0;
    while (instValid !== 1'b1 && n < 80) begin
      @(posedge mclk);
      #1;
      n++;
    end
    cmp(instValid, 16'h1);
    cmp(instOp, op);
    cmp(instLength, len);
    cmp(instNextPc, nxt);
    cmp(instUseY, y);
    cmp(instIndirect, ind);
    if (m[0]) cmp(instRelTarget, tgt);
    if (m[1]) cmp(instOperand, opnd);
    repeat (2) @(posedge mclk);
    instReady <= 1'b1;
    pcLoad <= ld;
    pcLoadValue <= ldv;
    @(posedge mclk);
    instReady <= 1'b0;
    pcLoad <= 1'b0;
    #1;
  endtask : take

  task automatic rel_direct;
    take(I_RELJUMP, 3'h2, 16'h2, 16'h7, 16'h5, 0, 0, 2'h3, 0, 16'h0);
    take(I_RELJUMP, 3'h2, 16'h4, 16'hFFF4, 16'hF0, 0, 0, 2'h1, 1,
      16'h10);
    cmp(instSel, 16'hF);
    cmp(instMode, AM_REL);
  endtask : rel_direct

  task automatic rel_indirect;
    slow <= 1'b1;
    take(I_RELJUMP, 3'h3, 16'h13, 16'h11, 16'hFE, 0, 1, 2'h3, 0,
      16'h0);
    take(I_RELCALL, 3'h2, 16'h15, 16'h94, 16'h7F, 0, 0, 2'h3, 0,
      16'h0);
    slow <= 1'b0;
  endtask : rel_indirect

  task automatic prefix_y;
    take(I_INC, 3'h2, 16'h17, 16'h0, 16'h0, 1, 0, 2'h0, 0, 16'h0);
    n0 = rsvdCnt;
    take(I_NOP, 3'h1, 16'h1A, 16'h0, 16'h0, 0, 0, 2'h0, 0, 16'h0);
    cmp(rsvdCnt - n0, 16'h1);
  endtask : prefix_y

  task automatic ind_indexed;
    take(I_LD, 3'h3, 16'h1D, 16'h0, 16'h55, 1, 1, 2'h2, 0, 16'h0);
    take(I_LD, 3'h3, 16'h20, 16'h0, 16'h55, 0, 1, 2'h2, 0, 16'h0);
    cmp(instMode, AM_IX8);
  endtask : ind_indexed

  task automatic long_forms;
    take(I_LD, 3'h3, 16'h23, 16'h0, 16'hFE12, 0, 1, 2'h2, 0, 16'h0);
    take(I_LD, 3'h4, 16'h27, 16'h0, 16'h1234, 1, 0, 2'h2, 0, 16'h0);
    take(I_BTJF, 3'h4, 16'h2B, 16'h2E, 16'h55, 0, 1, 2'h3, 0,
      16'h0);
  endtask : long_forms

  initial begin
    // Load after the model's own fill at time zero has run
    repeat (20) @(posedge mclk);
    for (int i = 0; i < 43; i++) memU.mem[i] = prog[i];
    memU.mem[8'h30] = 8'h55;
    memU.mem[8'h40] = 8'hFE;
    memU.mem[8'h41] = 8'h12;
    rstn <= 1'b1;
    rel_direct();
    rel_indirect();
    prefix_y();
    ind_indexed();
    long_forms();
    wrap_up();
  end
endmodule : prebyte_relative_decoder_tb_top
